// ### core/phy_paged_status_id_registers.sv
// Summary of operation
// R1: Peer speed field reports peer top speed: 000 S100, 001 S200, 010 S400.
// R2: Peer speed codes above S400 are never reported.
// R3: Peer speed is invalid after bus reset until self-ID completes.
// R4: With port interrupt enable set, a port event sets the flag and notifies link.
// R5: Interrupt enable and fault clear on hardware reset, survive bus reset.
// R6: Resume or suspend fault sets the port fault bit; port is then suspended.
// R7: Resume fault: resuming port sees no incoming cable bias.
// R8: Suspend fault: suspending port still sees incoming cable bias.
// R9: Writing 1 to the fault bit clears it; writing 0 leaves it.
// R10: Page select 1 maps upper addresses to vendor identification page.
// R11: Compliance level 01h is read at address 1000 of that page.
// R12: 24-bit organisation identifier over three bytes, MSB at 1010b.
// R13: Read-only 24-bit part identifier over three bytes, MSB at 1101b.
// R14: Page select 7 maps vendor-dependent page; other addresses reserved for test.
// R15: Hold bit set with acceleration: only packets over 8 bits clear requests.
// R16: Hold bit clear: any non-acknowledge packet clears fair and priority requests.
// R17: Null packet hold bit clears on hardware reset, survives bus reset.
// R18: Link speed 00 S100, 01 S200, 10 S400; code 11 is illegal.
// R19: Link speed is copied into the self-ID speed field.
// R20: S400 is always advertised to peer PHYs during self-ID.
// R21: Link speed loads 10b on hardware reset, survives bus reset.
// R22: Three-bit page select chooses the page at addresses 8 to 15.
// R23: Four-bit port select chooses the port, numbered from 0.
// R24: An unimplemented selected port reads all zero on the port status page.
// R25: Reserved bits and addresses read zero; writes to them do nothing.
`timescale 1ns/1ps
module phy_paged_status_id_registers
   import phy_page_pkg::*;
#(
   parameter logic [23:0] ORG_ID  = 24'h5a_a5_01,   // Arbitrary value
   parameter logic [23:0] PART_ID = 24'h00_00_01    // Arbitrary value
)(
   input  wire logic                       clk,                  // 200 MHz clock
   input  wire logic                       sys_rst,              // Hardware reset
   input  wire logic                       bus_reset,            // Bus reset pulse
   input  wire base_sel_t                  base_sel,             // Page and port select
   input  wire reg_req_t                   reg_req,              // Register request
   input  wire port_cond_t [NUM_PORTS-1:0] port_cond,            // Per-port conditions
   input  wire logic                       irq_flag_clear,       // Clear port event flag
   input  wire logic                       arb_accel_en,         // Arbitration acceleration on
   input  wire rx_pkt_t                    rx_pkt,               // Received packet end
   output logic                            reg_rd_valid,         // Read data strobe
   output logic [7:0]                      reg_rd_data,          // Read data
   output logic                            port_event_irq_flag,  // Port event flag
   output logic                            link_notify,          // Link notify pulse
   output logic [NUM_PORTS-1:0]            port_suspend,         // Port held suspended
   output logic                            fair_pri_clear,       // Clear pending requests
   output logic [1:0]                      self_id_rate_field,   // Self-ID speed field
   output logic [2:0]                      peer_advert_speed     // Speed shown to peers
);

   // ------------------------
   // Declarations
   // ------------------------
   top_st_t                st_r;
   top_st_t                st_nxt;
   port_st_t [NUM_PORTS-1:0] port_view;
   logic [NUM_PORTS-1:0]   port_event_hit;
   logic [NUM_PORTS-1:0]   port_wr_en;
   logic                   port_ok;
   logic                   wr_req;
   logic                   rd_req;
   logic                   status_wr;
   logic                   ctrl_wr;
   port_st_t               sel_view;
   logic [7:0]             rd_mux;
   logic                   pkt_is_ack;
   logic                   pkt_long;
   logic                   pkt_clears;

   // ------------------------
   // Request decode
   // ------------------------
   assign wr_req    = reg_req.req && reg_req.wr;
   assign rd_req    = reg_req.req && !reg_req.wr;
   assign port_ok   = base_sel.port < PORT_SEL_W'(NUM_PORTS);                       // R23 R24

   assign status_wr = wr_req && port_ok
                      && page_addr_hit(base_sel.page, reg_req.addr,
                                       PAGE_PORT_STATUS, ADDR_PORT_STATUS);          // R22
   assign ctrl_wr   = wr_req
                      && page_addr_hit(base_sel.page, reg_req.addr,
                                       PAGE_VENDOR_DEP, ADDR_VENDOR_CTRL);           // R14

   // ------------------------
   // Per-port state
   // ------------------------
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         assign port_wr_en[p] = status_wr && (base_sel.port == PORT_SEL_W'(p));     // R23

         port_fault_tracker u_port (
            .clk       (clk),
            .sys_rst   (sys_rst),
            .bus_reset (bus_reset),
            .cond      (port_cond[p]),
            .wr_en     (port_wr_en[p]),
            .wdata     (reg_req.wdata),
            .view      (port_view[p]),
            .event_hit (port_event_hit[p])
         );

         assign port_suspend[p] = port_view[p].fault;                                // R6
      end
   endgenerate

   // ------------------------
   // Read multiplexer
   // ------------------------
   always_comb begin
      sel_view = '0;
      if (port_ok) begin
         sel_view = port_view[base_sel.port[2:0]];
      end
   end

   always_comb begin
      rd_mux = 8'h00;                                                                // R25
      unique case (base_sel.page)
         PAGE_PORT_STATUS: begin
            if (port_ok && reg_req.addr == ADDR_PORT_STATUS) begin                 // R24
               if (sel_view.speed_valid) begin
                  rd_mux[PEER_SPEED_MSB:PEER_SPEED_LSB] = sel_view.peer_speed;      // R1 R3
               end
               rd_mux[IRQ_EN_BIT] = sel_view.irq_en;
               rd_mux[FAULT_BIT]  = sel_view.fault;
            end
         end
         PAGE_ORGANISATION_IDENTIFIER: begin                                                       // R10
            unique case (reg_req.addr)
               ADDR_COMPLIANCE: begin
                  rd_mux = COMPLIANCE_LEVEL;                                         // R11
               end
               ADDR_ORG_HI: begin
                  rd_mux = ORG_ID[23:16];                                            // R12
               end
               ADDR_ORG_MID: begin
                  rd_mux = ORG_ID[15:8];                                             // R12
               end
               ADDR_ORG_LO: begin
                  rd_mux = ORG_ID[7:0];                                              // R12
               end
               ADDR_PART_HI: begin
                  rd_mux = PART_ID[23:16];                                           // R13
               end
               ADDR_PART_MID: begin
                  rd_mux = PART_ID[15:8];                                            // R13
               end
               ADDR_PART_LO: begin
                  rd_mux = PART_ID[7:0];                                             // R13
               end
               default: begin
                  rd_mux = 8'h00;                                                    // R25
               end
            endcase
         end
         PAGE_VENDOR_DEP: begin                                                      // R14
            if (reg_req.addr == ADDR_VENDOR_CTRL) begin
               rd_mux[HOLD_BIT]                      = st_r.hold;
               rd_mux[LINK_SPEED_MSB:LINK_SPEED_LSB] = st_r.link_speed;
            end
         end
         default: begin
            rd_mux = 8'h00;                                                          // R25
         end
      endcase
   end

   // ------------------------
   // Received packet classification
   // ------------------------
   assign pkt_is_ack = rx_pkt.bit_count == ACK_PKT_BITS;
   assign pkt_long   = rx_pkt.bit_count > ACK_PKT_BITS;

   always_comb begin
      if (st_r.hold && arb_accel_en) begin
         pkt_clears = rx_pkt.done && pkt_long;                                       // R15
      end else begin
         pkt_clears = rx_pkt.done && !pkt_is_ack;                                    // R16
      end
   end

   // ------------------------
   // Next state
   // ------------------------
   always_comb begin
      st_nxt           = st_r;
      st_nxt.rd_valid  = rd_req;
      st_nxt.rd_data   = rd_req ? rd_mux : st_r.rd_data;
      st_nxt.notify    = |port_event_hit;                                            // R4
      st_nxt.req_clear = pkt_clears;

      if (ctrl_wr) begin
         st_nxt.hold = reg_req.wdata[HOLD_BIT];
         // An illegal speed code is refused and the old value kept
         if (reg_req.wdata[LINK_SPEED_MSB:LINK_SPEED_LSB] != LINK_ILLEGAL) begin   // R18
            st_nxt.link_speed = reg_req.wdata[LINK_SPEED_MSB:LINK_SPEED_LSB];
         end
      end

      // A new event wins over a clear in the same cycle
      if (irq_flag_clear) begin
         st_nxt.irq_flag = 1'b0;
      end
      if (|port_event_hit) begin
         st_nxt.irq_flag = 1'b1;                                                     // R4
      end

      st_nxt.self_id_rate = st_nxt.link_speed;                                       // R19
      st_nxt.advert_speed = PEER_S400;                                               // R20
   end

   // ------------------------
   // State register
   // ------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r.link_speed   <= LINK_SPEED_RST;                                        // R21
         st_r.hold         <= HOLD_RST;                                              // R17
         st_r.irq_flag     <= 1'b0;
         st_r.notify       <= 1'b0;
         st_r.req_clear    <= 1'b0;
         st_r.rd_valid     <= 1'b0;
         st_r.rd_data      <= 8'h00;
         st_r.self_id_rate <= LINK_SPEED_RST;
         st_r.advert_speed <= PEER_S400;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------
   // Outputs
   // ------------------------
   assign reg_rd_valid        = st_r.rd_valid;
   assign reg_rd_data         = st_r.rd_data;
   assign port_event_irq_flag = st_r.irq_flag;
   assign link_notify         = st_r.notify;
   assign fair_pri_clear      = st_r.req_clear;
   assign self_id_rate_field  = st_r.self_id_rate;
   assign peer_advert_speed   = st_r.advert_speed;

endmodule

// ### core/phy_page_pkg.sv
package phy_page_pkg;

   // ------------------------
   // Geometry
   // ------------------------
   localparam int          NUM_PORTS        = 6;
   localparam int          PORT_SEL_W       = 4;
   localparam int          PKT_BITS_W       = 16;

   // ------------------------
   // Pages and addresses of the upper register window
   // ------------------------
   localparam logic [2:0]  PAGE_PORT_STATUS = 3'h0;
   localparam logic [2:0]  PAGE_ORGANISATION_IDENTIFIER   = 3'h1;
   localparam logic [2:0]  PAGE_VENDOR_DEP  = 3'h7;
   localparam logic [3:0]  ADDR_PORT_STATUS = 4'h9;
   localparam logic [3:0]  ADDR_COMPLIANCE  = 4'h8;
   localparam logic [3:0]  ADDR_ORG_HI      = 4'ha;
   localparam logic [3:0]  ADDR_ORG_MID     = 4'hb;
   localparam logic [3:0]  ADDR_ORG_LO      = 4'hc;
   localparam logic [3:0]  ADDR_PART_HI     = 4'hd;
   localparam logic [3:0]  ADDR_PART_MID    = 4'he;
   localparam logic [3:0]  ADDR_PART_LO     = 4'hf;
   localparam logic [3:0]  ADDR_VENDOR_CTRL = 4'h8;

   // ------------------------
   // Field positions (bit position 7 of a row is the byte MSB)
   // ------------------------
   localparam int          PEER_SPEED_MSB   = 7;
   localparam int          PEER_SPEED_LSB   = 5;
   localparam int          IRQ_EN_BIT       = 4;
   localparam int          FAULT_BIT        = 3;
   localparam int          HOLD_BIT         = 7;
   localparam int          LINK_SPEED_MSB   = 1;
   localparam int          LINK_SPEED_LSB   = 0;

   // ------------------------
   // Codes and reset values
   // ------------------------
   localparam logic [7:0]  COMPLIANCE_LEVEL = 8'h01;
   localparam logic [2:0]  PEER_S100        = 3'h0;
   localparam logic [2:0]  PEER_S200        = 3'h1;
   localparam logic [2:0]  PEER_S400        = 3'h2;
   localparam logic [1:0]  LINK_S100        = 2'h0;
   localparam logic [1:0]  LINK_S200        = 2'h1;
   localparam logic [1:0]  LINK_S400        = 2'h2;
   localparam logic [1:0]  LINK_ILLEGAL     = 2'h3;
   localparam logic [1:0]  LINK_SPEED_RST   = 2'h2;
   localparam logic        HOLD_RST         = 1'h0;
   localparam logic        IRQ_EN_RST       = 1'h0;
   localparam logic        FAULT_RST        = 1'b0;
   localparam logic [15:0] ACK_PKT_BITS     = 16'h0008;

   // ------------------------
   // Carriers
   // ------------------------
   typedef struct packed {
      logic       req;
      logic       wr;
      logic [3:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [2:0]            page;
      logic [PORT_SEL_W-1:0] port;
   } base_sel_t;

   typedef struct packed {
      logic       port_event;
      logic       resume_check;
      logic       suspend_check;
      logic       bias;
      logic       speed_valid;
      logic [2:0] speed;
   } port_cond_t;

   typedef struct packed {
      logic                  done;
      logic [PKT_BITS_W-1:0] bit_count;
   } rx_pkt_t;

   typedef struct packed {
      logic       speed_valid;
      logic [2:0] peer_speed;
      logic       irq_en;
      logic       fault;
   } port_st_t;

   typedef struct packed {
      logic [1:0] link_speed;
      logic       hold;
      logic       irq_flag;
      logic       notify;
      logic       req_clear;
      logic       rd_valid;
      logic [7:0] rd_data;
      logic [1:0] self_id_rate;
      logic [2:0] advert_speed;
   } top_st_t;

   // ------------------------
   // Helpers
   // ------------------------
   function automatic logic page_addr_hit(input logic [2:0] page, input logic [3:0] addr,
                                          input logic [2:0] want_page, input logic [3:0] want_addr);
      page_addr_hit = (page == want_page) && (addr == want_addr);
   endfunction

   function automatic logic [2:0] clamp_peer_speed(input logic [2:0] code);
      clamp_peer_speed = (code > PEER_S400) ? PEER_S400 : code;
   endfunction

endpackage

// ### core/port_fault_tracker.sv
`timescale 1ns/1ps
module port_fault_tracker
   import phy_page_pkg::*;
(
   input  wire logic       clk,        // System clock
   input  wire logic       sys_rst,    // Hardware reset
   input  wire logic       bus_reset,  // Bus reset pulse
   input  wire port_cond_t cond,       // Line conditions of this port
   input  wire logic       wr_en,      // Write to this port's status byte
   input  wire logic [7:0] wdata,      // Write data
   output port_st_t        view,       // Registered port state
   output logic            event_hit   // Enabled port event this cycle
);

   port_st_t st_r;
   port_st_t st_nxt;
   logic     resume_fault;
   logic     suspend_fault;

   // ------------------------
   // Fault detection
   // ------------------------
   assign resume_fault  = cond.resume_check && !cond.bias;   // R7
   assign suspend_fault = cond.suspend_check && cond.bias;   // R8
   assign event_hit     = cond.port_event && st_r.irq_en;    // R4

   always_comb begin
      st_nxt = st_r;
      if (wr_en) begin
         st_nxt.irq_en = wdata[IRQ_EN_BIT];
         if (wdata[FAULT_BIT]) begin
            st_nxt.fault = 1'b0;                              // R9
         end
      end
      // Detection wins over a clearing write in the same cycle
      if (resume_fault || suspend_fault) begin
         st_nxt.fault = 1'b1;                                 // R6
      end
      // Bus reset invalidates only the peer speed
      if (bus_reset) begin
         st_nxt.speed_valid = 1'b0;                           // R3
         st_nxt.peer_speed  = PEER_S100;
      end else if (cond.speed_valid) begin
         st_nxt.speed_valid = 1'b1;
         st_nxt.peer_speed  = clamp_peer_speed(cond.speed);   // R1 R2
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r.speed_valid <= 1'b0;
         st_r.peer_speed  <= PEER_S100;
         st_r.irq_en      <= IRQ_EN_RST;                      // R5
         st_r.fault       <= FAULT_RST;                       // R5
      end else begin
         st_r <= st_nxt;
      end
   end

   assign view = st_r;

endmodule

// ### tb/phy_page_asserts.sv
`timescale 1ns/1ps
module phy_page_asserts
   import phy_page_pkg::*;
(
   input wire logic                       clk,                 // Clock
   input wire logic                       sys_rst,             // Reset
   input wire base_sel_t                  base_sel,            // Page, port
   input wire reg_req_t                   reg_req,             // Request
   input wire port_cond_t [NUM_PORTS-1:0] port_cond,           // Port lines
   input wire logic                       arb_accel_en,        // Accel on
   input wire rx_pkt_t                    rx_pkt,              // Packet end
   input wire logic [7:0]                 reg_rd_data,         // Read data
   input wire logic                       port_event_irq_flag, // Event flag
   input wire logic                       link_notify,         // Notify
   input wire logic [NUM_PORTS-1:0]       port_suspend,        // Suspended
   input wire logic                       fair_pri_clear,      // Req clear
   input wire logic [1:0]                 self_id_rate_field,  // Self-ID rate
   input wire logic [2:0]                 peer_advert_speed    // Advertised
);
   logic [NUM_PORTS-1:0] fault_ev;
   logic                 ev_any;
   always_comb begin
      ev_any = 1'h0;
      for (int i = 0; i < NUM_PORTS; i++) begin
         fault_ev[i] = (port_cond[i].resume_check & ~port_cond[i].bias) |
                       (port_cond[i].suspend_check & port_cond[i].bias);
         ev_any      = ev_any | port_cond[i].port_event;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ------------------------
   // Read request of one page and address
   // ------------------------
   sequence s_rd(pg, ad);
      reg_req.req && !reg_req.wr && base_sel.page == pg && reg_req.addr == ad;
   endsequence
   property p_compliance; s_rd(PAGE_ORGANISATION_IDENTIFIER, ADDR_COMPLIANCE) |=> reg_rd_data == COMPLIANCE_LEVEL; endproperty
   a_compliance: assert property (p_compliance) else $error("compliance level wrong");
   property p_rate_copy; s_rd(PAGE_VENDOR_DEP, ADDR_VENDOR_CTRL) |=> self_id_rate_field == reg_rd_data[1:0]; endproperty
   a_rate_copy: assert property (p_rate_copy) else $error("self-id rate differs");
   property p_advert; peer_advert_speed == PEER_S400; endproperty
   a_advert: assert property (p_advert) else $error("advertised speed wrong");
   property p_peer_range; s_rd(PAGE_PORT_STATUS, ADDR_PORT_STATUS) |=> reg_rd_data[7:5] <= PEER_S400; endproperty
   a_peer_range: assert property (p_peer_range) else $error("peer speed out of range");
   property p_unimpl; reg_req.req && !reg_req.wr && base_sel.page == PAGE_PORT_STATUS
      && base_sel.port >= NUM_PORTS |=> reg_rd_data == 8'h00; endproperty
   a_unimpl: assert property (p_unimpl) else $error("absent port not zero");
   property p_test_rsvd; reg_req.req && !reg_req.wr && base_sel.page == PAGE_VENDOR_DEP
      && reg_req.addr > 4'h8 |=> reg_rd_data == 8'h00; endproperty
   a_test_rsvd: assert property (p_test_rsvd) else $error("test address not zero");
   property p_fault_set; fault_ev != '0 |=> (port_suspend & $past(fault_ev)) == $past(fault_ev); endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault did not suspend");
   property p_notify; link_notify |-> port_event_irq_flag && $past(ev_any); endproperty
   a_notify: assert property (p_notify) else $error("notify without event");
   property p_ack_keep; rx_pkt.done && rx_pkt.bit_count == ACK_PKT_BITS |=> !fair_pri_clear; endproperty
   a_ack_keep: assert property (p_ack_keep) else $error("ack cleared requests");
   property p_nonack; rx_pkt.done && !arb_accel_en && rx_pkt.bit_count != ACK_PKT_BITS |=> fair_pri_clear;
   endproperty
   a_nonack: assert property (p_nonack) else $error("packet left requests");
   property p_link_legal; self_id_rate_field != LINK_ILLEGAL; endproperty
   a_link_legal: assert property (p_link_legal) else $error("illegal link speed");
endmodule

bind phy_paged_status_id_registers phy_page_asserts chk (.clk(clk), .sys_rst(sys_rst), .base_sel(base_sel),
   .reg_req(reg_req), .port_cond(port_cond), .arb_accel_en(arb_accel_en), .rx_pkt(rx_pkt),
   .reg_rd_data(reg_rd_data), .port_event_irq_flag(port_event_irq_flag), .link_notify(link_notify),
   .port_suspend(port_suspend), .fair_pri_clear(fair_pri_clear), .self_id_rate_field(self_id_rate_field),
   .peer_advert_speed(peer_advert_speed));

// ### tb/llc_model.sv
`timescale 1ns/1ps
module llc_model
   import phy_page_pkg::*;
(
   input  wire logic       clk,      // Clock
   input  wire logic       rd_valid, // Read strobe
   input  wire logic [7:0] rd_data,  // Read data
   output reg_req_t        req,      // Request
   output base_sel_t       sel       // Page, port
);
   initial begin
      req = '0;
      sel = '0;
   end
   // Request stands one edge; released qualifiers are inverted, not left stale
   task automatic access(input logic [2:0] pg, input logic [3:0] pt, input logic wr, input logic [3:0] ad,
                         input logic [7:0] wd, output logic [7:0] rd, output logic ok);
      @(posedge clk);
      sel <= '{pg, pt};
      req <= '{1'b1, wr, ad, wd};
      @(posedge clk);
      req <= '{1'b0, ~wr, ~ad, ~wd};
      #1;
      ok = rd_valid ^ wr;
      rd = rd_data;
   endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import phy_page_pkg::*;
   localparam logic [23:0] ORG  = 24'h3c_71_9e; // Arbitrary value
   localparam logic [23:0] PART = 24'h00_b4_27; // Arbitrary value
   logic clk = 1'b0, sys_rst = 1'b1, bus_reset = 1'b0, irq_flag_clear = 1'b0, arb_accel_en = 1'b0;
   port_cond_t [NUM_PORTS-1:0] port_cond = '0;
   rx_pkt_t                    rx_pkt = '0;
   reg_req_t                   reg_req;
   base_sel_t                  base_sel;
   logic                       reg_rd_valid, port_event_irq_flag, link_notify, fair_pri_clear, ok;
   logic [7:0]                 reg_rd_data, rd;
   logic [NUM_PORTS-1:0]       port_suspend;
   logic [1:0]                 self_id_rate_field;
   logic [2:0]                 peer_advert_speed;
   int                         fail_count = 0, samples_checked = 0;
   always #2.5 clk = ~clk;
   phy_paged_status_id_registers #(.ORG_ID(ORG), .PART_ID(PART)) dut (.clk(clk), .sys_rst(sys_rst),
      .bus_reset(bus_reset), .base_sel(base_sel), .reg_req(reg_req), .port_cond(port_cond),
      .irq_flag_clear(irq_flag_clear), .arb_accel_en(arb_accel_en), .rx_pkt(rx_pkt),
      .reg_rd_valid(reg_rd_valid), .reg_rd_data(reg_rd_data), .port_event_irq_flag(port_event_irq_flag),
      .link_notify(link_notify), .port_suspend(port_suspend), .fair_pri_clear(fair_pri_clear),
      .self_id_rate_field(self_id_rate_field), .peer_advert_speed(peer_advert_speed));
   llc_model llc (.clk(clk), .rd_valid(reg_rd_valid), .rd_data(reg_rd_data), .req(reg_req), .sel(base_sel));
   // ------------------------
   // Access and compare tasks
   // ------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] pg, input logic [3:0] pt, input logic [3:0] ad, input logic [7:0] d);
      llc.access(pg, pt, 1'b1, ad, d, rd, ok);
      chk("write strobe", 8'h01, {7'h0, ok});
   endtask
   task automatic rc(input logic [2:0] pg, input logic [3:0] pt, input logic [3:0] ad, input logic [7:0] e);
      llc.access(pg, pt, 1'b0, ad, 8'h00, rd, ok);
      chk("read strobe", 8'h01, {7'h0, ok});
      chk($sformatf("page %0d port %0d addr %h", pg, pt, ad), e, rd);
   endtask
   task automatic pc(input int p, input logic [7:0] c);
      @(posedge clk);
      port_cond[p] <= port_cond_t'(c);
      @(posedge clk);
      port_cond[p] <= port_cond_t'(c & 8'h17);
      #1;
   endtask
   task automatic pk(input logic [15:0] b, input logic e);
      @(posedge clk);
      rx_pkt <= '{1'b1, b};
      @(posedge clk);
      rx_pkt <= '{1'b0, ~b};
      #1;
      chk("request clear", {7'h0, e}, {7'h0, fair_pri_clear});
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      give_verdict();
   end
   // ------------------------
   // Test sequence
   // ------------------------
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rc(3'h7, 4'h0, 4'h8, 8'h02);
      chk("self-id rate", 8'h02, {6'h0, self_id_rate_field});
      chk("advertised speed", 8'h02, {5'h0, peer_advert_speed});
      wr(3'h1, 4'h0, 4'h8, 8'hff);
      rc(3'h1, 4'h0, 4'h8, 8'h01);
      rc(3'h1, 4'h0, 4'h9, 8'h00);
      for (int i = 0; i < 3; i++) begin
         rc(3'h1, 4'h0, 4'ha + 4'(i), ORG[23-8*i -: 8]);
         rc(3'h1, 4'h0, 4'hd + 4'(i), PART[23-8*i -: 8]);
      end
      for (int s = 0; s < 3; s++) begin
         wr(3'h7, 4'h0, 4'h8, {s[0], 5'h1f, s[1:0]});
         rc(3'h7, 4'h0, 4'h8, {s[0], 5'h00, s[1:0]});
         chk("self-id rate", {6'h0, s[1:0]}, {6'h0, self_id_rate_field});
      end
      wr(3'h7, 4'h0, 4'h8, 8'h83);
      rc(3'h7, 4'h0, 4'h8, 8'h82);
      for (int a = 9; a < 16; a++) begin
         wr(3'h7, 4'h0, 4'(a), 8'hff);
         rc(3'h7, 4'h0, 4'(a), 8'h00);
      end
      for (int c = 0; c < 8; c++) begin
         pc(2, {5'h01, 3'(c)});
         rc(3'h0, 4'h2, 4'h9, {((c > 2) ? 3'h2 : 3'(c)), 5'h00});
      end
      rc(3'h0, 4'h4, 4'h9, 8'h00);
      wr(3'h0, 4'h3, 4'h9, 8'hf7);
      rc(3'h0, 4'h3, 4'h9, 8'h10);
      pc(3, 8'h80);
      chk("notify", 8'h01, {7'h0, link_notify});
      chk("event flag", 8'h01, {7'h0, port_event_irq_flag});
      pc(4, 8'h80);
      chk("notify", 8'h00, {7'h0, link_notify});
      @(posedge clk);
      irq_flag_clear <= 1'b1;
      @(posedge clk);
      irq_flag_clear <= 1'b0;
      #1;
      chk("event flag", 8'h00, {7'h0, port_event_irq_flag});
      pc(1, 8'h40);
      pc(2, 8'h30);
      pc(0, 8'h50);
      pc(5, 8'h20);
      chk("suspended ports", 8'h06, {2'h0, port_suspend});
      rc(3'h0, 4'h2, 4'h9, 8'h48);
      wr(3'h0, 4'h1, 4'h9, 8'h00);
      rc(3'h0, 4'h1, 4'h9, 8'h08);
      wr(3'h0, 4'h1, 4'h9, 8'h08);
      rc(3'h0, 4'h1, 4'h9, 8'h00);
      rc(3'h0, 4'h7, 4'h9, 8'h00);
      rc(3'h0, 4'ha, 4'h9, 8'h00);
      pk(16'h0000, 1'b1);
      pk(16'h0008, 1'b0);
      pk(16'h0010, 1'b1);
      @(posedge clk);
      arb_accel_en <= 1'b1;
      pk(16'h0000, 1'b0);
      pk(16'h0007, 1'b0);
      pk(16'h0008, 1'b0);
      pk(16'h0009, 1'b1);
      wr(3'h7, 4'h0, 4'h8, 8'h01);
      pk(16'h0000, 1'b1);
      pk(16'h0005, 1'b1);
      wr(3'h7, 4'h0, 4'h8, 8'h81);
      @(posedge clk);
      bus_reset <= 1'b1;
      @(posedge clk);
      bus_reset <= 1'b0;
      rc(3'h0, 4'h3, 4'h9, 8'h10);
      rc(3'h0, 4'h2, 4'h9, 8'h08);
      rc(3'h7, 4'h0, 4'h8, 8'h81);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rc(3'h0, 4'h3, 4'h9, 8'h00);
      rc(3'h0, 4'h2, 4'h9, 8'h00);
      rc(3'h7, 4'h0, 4'h8, 8'h02);
      chk("suspended ports", 8'h00, {2'h0, port_suspend});
      give_verdict();
   end
endmodule
